// *** hdl/pssq_pkg.sv ***
/*
 pssq_pkg: constants and types for the power source and mode sequencer.
 Assumes a 20 MHz register clock. AHB-Lite register map with 32-bit words.
*/
package pssq_pkg;
   // register byte offsets
   localparam logic [7:0] PSSQ_CTRL_OFS = 8'h00;
   localparam logic [7:0] PSSQ_STAT_OFS = 8'h04;
   localparam logic [7:0] PSSQ_CLKDIV_OFS = 8'h08;
   localparam logic [7:0] PSSQ_WAKE_OFS = 8'h0C;
   // control register fields
   localparam int PSSQ_CTRL_AUTO_DIS = 0;
   localparam int PSSQ_CTRL_BAT_OPEN = 1;
   localparam int PSSQ_CTRL_DPD_REQ = 2;
   localparam int PSSQ_CTRL_SLEEP_REQ = 3;
   localparam int PSSQ_CTRL_DEEP_REQ = 4;
   localparam int PSSQ_CTRL_BOD_EN = 5;
   localparam int PSSQ_CTRL_SW_RST = 6;
   localparam int PSSQ_CTRL_BAT_OVR = 7;
   localparam int PSSQ_CTRL_DIG_OFF = 8;
   localparam int PSSQ_CTRL_ANA_OFF = 9;
   localparam int PSSQ_CTRL_W = 10;
   // wake enable fields
   localparam int PSSQ_WAKE_PIN_EN = 0;
   localparam int PSSQ_WAKE_RF_EN = 1;
   localparam int PSSQ_WAKE_W = 2;
   // reset values
   localparam logic [9:0] PSSQ_CTRL_RST = 10'h000;
   localparam logic [2:0] PSSQ_CLKDIV_RST = 3'h4;
   localparam logic [1:0] PSSQ_WAKE_RST = 2'h0;
   // timing
   localparam int PSSQ_CLK_KHZ = 20000;
   localparam int PSSQ_WAKE_LOW_US = 100;
   localparam int PSSQ_WAKE_LOW_CYC = (PSSQ_WAKE_LOW_US * PSSQ_CLK_KHZ + 999) / 1000;
   localparam int PSSQ_BOOT_US = 2500;
   localparam int PSSQ_BOOT_CYC = (PSSQ_BOOT_US * PSSQ_CLK_KHZ) / 1000;
   typedef enum logic [2:0] {
      PSSQ_BATOFF, PSSQ_DIGUP, PSSQ_ANAUP, PSSQ_BOOT, PSSQ_ACTIVE, PSSQ_SLEEP, PSSQ_DPD
   } pssq_state_t;
endpackage

// *** hdl/pssq_top.sv ***
/*
 pssq_top: power source selection, power mode state machine, power-up
 sequencing, wake and reset source handling, system clock divider select.
 Assumes supply comparator, pin and detector inputs are asynchronous;
 oscillator-ready and flash-ready come from the same clock domain.
*/
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
// Functional notes
// R1 - both sources good: battery feeds domains
// R2 - weak battery, RF higher: RF feeds
// R3 - battery switch open until reset rise/RF
// R4 - battery lost: switch to RF immediately
// R5 - auto disable forces battery, comparator off
// R6 - RF switch closes whenever field present
// R7 - no RF: command opens battery switch
// R8 - five modes drive domain power
// R9 - mode flags and regulators per state
// R10 - enabled brownout below 1.8V raises interrupt
// R11 - independent regulator enables
// R12 - first sequencer state enables digital regulator
// R13 - second state enables analog regulator
// R14 - system reset after regulator and oscillator
// R15 - boot waits for flash ready
// R16 - RF-only start runs same sequence
// R17 - slow oscillator never disabled
// R18 - deep-sleep wake sources
// R19 - deep power-down wake sources
// R20 - host holds wake low 100us
// R21 - clock divider default 500kHz, eight steps
// R22 - reset sources pin, watchdog, software
// R23 - battery-off left by reset rise/RF
`timescale 1ns/100ps
module pssq_top
   import pssq_pkg::*;
#(
   parameter int BOOT_CYC = PSSQ_BOOT_CYC
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic BAT_GOOD,
   input wire logic RF_GOOD,
   input wire logic RF_FIELD,
   input wire logic RESET_PIN_B,
   input wire logic WAKE_PIN,
   input wire logic BROWNOUT_LOW,
   input wire logic RTC_EVENT,
   input wire logic WDT_EVENT,
   input wire logic START_IRQ,
   input wire logic FAST_OSC_OK,
   input wire logic FLASH_READY,
   output logic BAT_SWITCH_ON,
   output logic RF_SWITCH_ON,
   output logic SRC_IS_RF,
   output logic CMP_EN,
   output logic ALWAYS_ON_PWR,
   output logic DIG_REG_EN,
   output logic ANA_REG_EN,
   output logic SLOW_OSC_EN,
   output logic SYS_POR_B,
   output logic BOOT_EN,
   output logic DPD_FLAG,
   output logic SLEEP_FLAG,
   output logic DEEP_SLEEP,
   output logic BOD_IRQ,
   output logic SYS_RST_B,
   output logic [2:0] CLK_DIV_SEL
);
   if (BOOT_CYC < 1) begin : g_boot_cyc_chk
      $error("BOOT_CYC must be at least 1");
   end

   localparam int NSYNC = 7;
   localparam int WCW = $clog2(PSSQ_WAKE_LOW_CYC + 1);
   localparam int BCW = $clog2(BOOT_CYC + 1);
   // reset pin idles high; starting its stages low would fake a rising edge after reset
   localparam logic [NSYNC-1:0] SYNC_RST = 7'h08;

   // three-stage synchronisers; a change counts when stages two and three agree
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, f_reg;
   assign raw_in = {RTC_EVENT, BROWNOUT_LOW, WAKE_PIN, RESET_PIN_B, RF_FIELD, RF_GOOD,
                    BAT_GOOD};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge CLK) begin
            if (!RST_B) begin
               s1_reg[gi] <= SYNC_RST[gi];
               s2_reg[gi] <= SYNC_RST[gi];
               s3_reg[gi] <= SYNC_RST[gi];
               f_reg[gi] <= SYNC_RST[gi];
            end else begin
               s1_reg[gi] <= raw_in[gi];
               s2_reg[gi] <= s1_reg[gi];
               s3_reg[gi] <= s2_reg[gi];
               if (s2_reg[gi] == s3_reg[gi]) f_reg[gi] <= s3_reg[gi];
            end
         end
      end
   endgenerate
   wire bat_ok = f_reg[0];
   wire rf_ok = f_reg[1];
   wire field = f_reg[2];
   wire rstpin_b = f_reg[3];
   wire wake_pin = f_reg[4];
   wire bod_low = f_reg[5];
   wire rtc = f_reg[6];

   logic rstpin_q_reg;
   wire rstpin_rise = rstpin_b && !rstpin_q_reg;
   wire rstpin_low = !rstpin_b;

   // registers
   logic [PSSQ_CTRL_W-1:0] ctrl_reg;
   logic [2:0] clkdiv_reg;
   logic [PSSQ_WAKE_W-1:0] wake_reg;
   logic sw_rst_reg;
   logic bat_closed_reg;
   logic bod_irq_reg;
   pssq_state_t state_reg, state_next;
   logic [BCW-1:0] boot_cnt_reg;
   logic [WCW-1:0] wake_cnt_reg;

   // ahb-lite slave: zero wait state, always OKAY
   logic wr_pend_reg;
   logic [7:0] addr_reg;
   wire take = HSEL && HREADY && HTRANS[1];
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   // power source selection
   wire auto_dis = ctrl_reg[PSSQ_CTRL_AUTO_DIS];
   assign CMP_EN = !auto_dis; // see R5
   wire bat_usable = bat_closed_reg && !ctrl_reg[PSSQ_CTRL_BAT_OVR];
   // rf only when battery unusable and rf present; auto disable pins battery
   assign SRC_IS_RF = !auto_dis && !(bat_usable && bat_ok) && rf_ok; // see R1 see R2 see R4
   assign RF_SWITCH_ON = field; // see R6
   assign BAT_SWITCH_ON = bat_closed_reg;
   assign ALWAYS_ON_PWR = bat_closed_reg || field; // see R8
   assign SLOW_OSC_EN = 1'b1; // see R17

   // wake logic
   wire wake_pin_ev = wake_reg[PSSQ_WAKE_PIN_EN] && (wake_cnt_reg == WCW'(PSSQ_WAKE_LOW_CYC));
   wire rf_ev = wake_reg[PSSQ_WAKE_RF_EN] && field;
   wire ds_wake = rstpin_low || rtc || WDT_EVENT || wake_pin || rf_ev || START_IRQ; // see R18
   wire dpd_wake = rstpin_low || rtc || wake_pin_ev || rf_ev; // see R19
   wire bat_off_cmd = ctrl_reg[PSSQ_CTRL_BAT_OPEN] && !field; // see R7

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PSSQ_BATOFF: if (ALWAYS_ON_PWR) state_next = PSSQ_DIGUP; // see R16 see R23
         PSSQ_DIGUP: state_next = PSSQ_ANAUP; // see R12
         PSSQ_ANAUP: if (FAST_OSC_OK) state_next = PSSQ_BOOT; // see R13
         PSSQ_BOOT: if (FLASH_READY && boot_cnt_reg == '0) state_next = PSSQ_ACTIVE; // see R15
         PSSQ_ACTIVE: begin
            if (bat_off_cmd) state_next = PSSQ_BATOFF;
            else if (ctrl_reg[PSSQ_CTRL_DPD_REQ]) state_next = PSSQ_DPD;
            else if (ctrl_reg[PSSQ_CTRL_SLEEP_REQ]) state_next = PSSQ_SLEEP;
         end
         PSSQ_SLEEP: if (ds_wake) state_next = PSSQ_ACTIVE;
         PSSQ_DPD: if (dpd_wake) state_next = PSSQ_DIGUP;
         default: state_next = PSSQ_BATOFF;
      endcase
   end

   wire st_up = (state_reg == PSSQ_ACTIVE) || (state_reg == PSSQ_SLEEP);
   wire seq_dig = st_up || (state_reg == PSSQ_DIGUP) || (state_reg == PSSQ_ANAUP) ||
                  (state_reg == PSSQ_BOOT);
   wire seq_ana = seq_dig && (state_reg != PSSQ_DIGUP);

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         state_reg <= PSSQ_BATOFF;
         bat_closed_reg <= 1'b0;
         rstpin_q_reg <= 1'b1;
         boot_cnt_reg <= '0;
         wake_cnt_reg <= '0;
         bod_irq_reg <= 1'b0;
         DIG_REG_EN <= 1'b0;
         ANA_REG_EN <= 1'b0;
         SYS_POR_B <= 1'b0;
         BOOT_EN <= 1'b0;
         DPD_FLAG <= 1'b0;
         SLEEP_FLAG <= 1'b0;
         DEEP_SLEEP <= 1'b0;
         SYS_RST_B <= 1'b0;
      end else begin
         state_reg <= state_next;
         rstpin_q_reg <= rstpin_b;
         // battery switch closes on reset-pin rise or rf, opens on command; a trigger wins
         if (rstpin_rise || field) bat_closed_reg <= 1'b1; // see R3 see R23
         else if (bat_off_cmd && state_reg == PSSQ_ACTIVE) bat_closed_reg <= 1'b0; // see R7
         if (state_reg == PSSQ_ANAUP && state_next == PSSQ_BOOT) begin
            boot_cnt_reg <= BCW'(BOOT_CYC);
         end else if (boot_cnt_reg != '0) begin
            boot_cnt_reg <= boot_cnt_reg - 1'b1;
         end
         // wake pin low time, counted only in deep power-down
         if (state_reg != PSSQ_DPD || wake_pin) wake_cnt_reg <= '0;
         else if (wake_cnt_reg != WCW'(PSSQ_WAKE_LOW_CYC)) wake_cnt_reg <= wake_cnt_reg + 1'b1;
         bod_irq_reg <= ctrl_reg[PSSQ_CTRL_BOD_EN] && bod_low && ALWAYS_ON_PWR; // see R10
         DIG_REG_EN <= seq_dig && !ctrl_reg[PSSQ_CTRL_DIG_OFF]; // see R11 see R12
         ANA_REG_EN <= seq_ana && !ctrl_reg[PSSQ_CTRL_ANA_OFF]; // see R11 see R13
         SYS_POR_B <= seq_ana && (state_reg != PSSQ_ANAUP || FAST_OSC_OK); // see R14
         BOOT_EN <= st_up; // see R15
         DPD_FLAG <= (state_reg == PSSQ_DPD); // see R9
         SLEEP_FLAG <= (state_reg == PSSQ_SLEEP); // see R9
         DEEP_SLEEP <= (state_reg == PSSQ_SLEEP) && ctrl_reg[PSSQ_CTRL_DEEP_REQ];
         SYS_RST_B <= seq_ana && !rstpin_low && !WDT_EVENT && !sw_rst_reg; // see R22
      end
   end
   assign BOD_IRQ = bod_irq_reg;
   assign CLK_DIV_SEL = clkdiv_reg;

   // register writes; dpd, sleep and battery-open requests self-clear while the state machine is outside active
   wire wr_ctrl = wr_pend_reg && addr_reg == PSSQ_CTRL_OFS;
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
         ctrl_reg <= PSSQ_CTRL_RST;
         clkdiv_reg <= PSSQ_CLKDIV_RST; // see R21
         wake_reg <= PSSQ_WAKE_RST;
         sw_rst_reg <= 1'b0;
      end else begin
         wr_pend_reg <= take && HWRITE;
         if (take) addr_reg <= HADDR[7:0];
         sw_rst_reg <= wr_ctrl && HWDATA[PSSQ_CTRL_SW_RST];
         if (wr_ctrl) ctrl_reg <= HWDATA[PSSQ_CTRL_W-1:0];
         else if (state_reg != PSSQ_ACTIVE) begin
            ctrl_reg[PSSQ_CTRL_DPD_REQ] <= 1'b0;
            ctrl_reg[PSSQ_CTRL_SLEEP_REQ] <= 1'b0;
            ctrl_reg[PSSQ_CTRL_BAT_OPEN] <= 1'b0;
         end
         if (wr_pend_reg && addr_reg == PSSQ_CLKDIV_OFS) clkdiv_reg <= HWDATA[2:0]; // see R21
         if (wr_pend_reg && addr_reg == PSSQ_WAKE_OFS) wake_reg <= HWDATA[PSSQ_WAKE_W-1:0];
      end
   end

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (HADDR[7:0])
         PSSQ_CTRL_OFS: rd_mux = {22'h0, ctrl_reg};
         PSSQ_STAT_OFS: rd_mux = {22'h0, bod_irq_reg, SRC_IS_RF, bat_closed_reg,
                                  field, bat_ok, rf_ok, 1'b0, state_reg};
         PSSQ_CLKDIV_OFS: rd_mux = {29'h0, clkdiv_reg};
         PSSQ_WAKE_OFS: rd_mux = {30'h0, wake_reg};
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge CLK) begin
      if (!RST_B) HRDATA <= 32'h0000_0000;
      else if (take && !HWRITE) HRDATA <= rd_mux;
      else HRDATA <= 32'h0000_0000;
   end

   a_boot_flash_rdy: assert property (@(posedge CLK) disable iff (!RST_B) // see R15
      $rose(BOOT_EN) |-> $past(FLASH_READY, 2))
      else $error("boot without flash ready");
   a_boot_after_flash: assert property (@(posedge CLK) disable iff (!RST_B) // see R15
      $rose(BOOT_EN) |-> $past(state_reg) == PSSQ_ACTIVE)
      else $error("boot enable outside active");
   a_cmp_auto: assert property (@(posedge CLK) disable iff (!RST_B) // see R5
      auto_dis |-> !CMP_EN && !SRC_IS_RF)
      else $error("auto disable not forcing battery");
   a_rf_switch: assert property (@(posedge CLK) disable iff (!RST_B) // see R6
      $rose(f_reg[2]) |-> RF_SWITCH_ON ##1 bat_closed_reg)
      else $error("rf field did not close switches");
   a_dpd_flags: assert property (@(posedge CLK) disable iff (!RST_B) // see R9
      state_reg == PSSQ_DPD ##1 state_reg == PSSQ_DPD |-> DPD_FLAG && !SLEEP_FLAG && !DIG_REG_EN)
      else $error("deep power-down encoding wrong");
   a_seq_order: assert property (@(posedge CLK) disable iff (!RST_B) // see R13
      state_reg == PSSQ_DIGUP && !ctrl_reg[PSSQ_CTRL_DIG_OFF] |=> DIG_REG_EN && !ANA_REG_EN)
      else $error("analog regulator before digital");
   a_bod: assert property (@(posedge CLK) disable iff (!RST_B) // see R10
      ctrl_reg[PSSQ_CTRL_BOD_EN] && bod_low && ALWAYS_ON_PWR |=> BOD_IRQ)
      else $error("brownout interrupt missing");
   a_batoff_stay: assert property (@(posedge CLK) disable iff (!RST_B) // see R23
      state_reg == PSSQ_BATOFF && !ALWAYS_ON_PWR |=> state_reg == PSSQ_BATOFF)
      else $error("left battery-off without trigger");
   a_clkdiv_rst: assert property (@(posedge CLK) // see R21
      !RST_B |=> CLK_DIV_SEL == PSSQ_CLKDIV_RST)
      else $error("clock divider reset value wrong");
   a_src_rf: assert property (@(posedge CLK) disable iff (!RST_B) // see R4
      !auto_dis && !bat_ok && rf_ok |-> SRC_IS_RF)
      else $error("no switchover to rf");
   a_src_bat: assert property (@(posedge CLK) disable iff (!RST_B) // see R1
      !auto_dis && bat_usable && bat_ok |-> !SRC_IS_RF)
      else $error("battery good but rf selected");
   a_bat_idle: assert property (@(posedge CLK) disable iff (!RST_B) // see R3
      !bat_closed_reg && !rstpin_rise && !field |=> !BAT_SWITCH_ON)
      else $error("battery switch closed without trigger");
   a_bat_open: assert property (@(posedge CLK) disable iff (!RST_B) // see R7
      bat_off_cmd && !rstpin_rise && state_reg == PSSQ_ACTIVE
      |=> !BAT_SWITCH_ON && state_reg == PSSQ_BATOFF)
      else $error("battery switch not opened on command");
   a_aon_pwr: assert property (@(posedge CLK) disable iff (!RST_B) // see R8
      state_reg != PSSQ_BATOFF |-> ALWAYS_ON_PWR)
      else $error("always-on domain unpowered outside battery-off");
   a_dpd_enter: assert property (@(posedge CLK) disable iff (!RST_B) // see R8
      state_reg == PSSQ_ACTIVE && !bat_off_cmd && ctrl_reg[PSSQ_CTRL_DPD_REQ]
      |=> state_reg == PSSQ_DPD)
      else $error("deep power-down request not taken");
   a_sleep_deep: assert property (@(posedge CLK) disable iff (!RST_B) // see R8
      state_reg == PSSQ_SLEEP && ctrl_reg[PSSQ_CTRL_DEEP_REQ] |=> DEEP_SLEEP)
      else $error("deep-sleep indication missing");
   a_active_flags: assert property (@(posedge CLK) disable iff (!RST_B) // see R9
      state_reg == PSSQ_ACTIVE ##1 state_reg == PSSQ_ACTIVE |-> !SLEEP_FLAG && !DPD_FLAG && BOOT_EN)
      else $error("active encoding wrong");
   a_sleep_flags: assert property (@(posedge CLK) disable iff (!RST_B) // see R9
      state_reg == PSSQ_SLEEP ##1 state_reg == PSSQ_SLEEP |-> SLEEP_FLAG && !DPD_FLAG)
      else $error("sleep encoding wrong");
   a_bod_quiet: assert property (@(posedge CLK) disable iff (!RST_B) // see R10
      !ctrl_reg[PSSQ_CTRL_BOD_EN] |=> !BOD_IRQ)
      else $error("brownout interrupt while disabled");
   a_por_gate: assert property (@(posedge CLK) disable iff (!RST_B) // see R14
      $rose(SYS_POR_B) |-> $past(FAST_OSC_OK) && $past(state_reg) == PSSQ_ANAUP)
      else $error("system reset released before oscillator ready");
   a_rf_start: assert property (@(posedge CLK) disable iff (!RST_B) // see R16
      state_reg == PSSQ_BATOFF && field |=> state_reg == PSSQ_DIGUP)
      else $error("rf field did not start power-up");
   a_sleep_wake: assert property (@(posedge CLK) disable iff (!RST_B) // see R18
      state_reg == PSSQ_SLEEP && ds_wake |=> state_reg == PSSQ_ACTIVE)
      else $error("deep-sleep wake missed");
   a_dpd_wake_only: assert property (@(posedge CLK) disable iff (!RST_B) // see R19
      state_reg == PSSQ_DPD && !dpd_wake |=> state_reg == PSSQ_DPD)
      else $error("deep power-down left without wake source");
   a_clkdiv_hold: assert property (@(posedge CLK) disable iff (!RST_B) // see R21
      !(wr_pend_reg && addr_reg == PSSQ_CLKDIV_OFS) |=> $stable(CLK_DIV_SEL))
      else $error("clock divider changed without write");
   a_sw_rst: assert property (@(posedge CLK) disable iff (!RST_B) // see R22
      sw_rst_reg |=> !SYS_RST_B)
      else $error("software reset not applied");
   a_wdt_rst: assert property (@(posedge CLK) disable iff (!RST_B) // see R22
      WDT_EVENT |=> !SYS_RST_B)
      else $error("watchdog reset not applied");
endmodule

// *** tb/pssq_far.sv ***
/*
 pssq_far: behavioural far side, fast oscillator and flash readiness.
 Assumes the regulator enables come from the block under test.
*/
`timescale 1ns/100ps
module pssq_far (
   input wire logic CLK,
   input wire logic SLOW,
   input wire logic DIG_REG_EN,
   input wire logic ANA_REG_EN,
   output logic FAST_OSC_OK,
   output logic FLASH_READY
);
   int osc_cnt = 0;
   int fl_cnt = 0;
   // readiness drops with its supply; slow mode outlasts the short boot count
   always @(posedge CLK) begin
      osc_cnt <= DIG_REG_EN ? osc_cnt + 1 : 0;
      fl_cnt <= ANA_REG_EN ? fl_cnt + 1 : 0;
   end
   assign FAST_OSC_OK = osc_cnt > (SLOW ? 30 : 3);
   assign FLASH_READY = fl_cnt > (SLOW ? 40 : 2);
endmodule

// *** tb/pssq_top_tb.sv ***
/*
 pssq_top_tb: self-checking bench for the power sequencer.
 Assumes pssq_top with a short boot count and the pssq_far model.
*/
`timescale 1ns/100ps
module pssq_top_tb;
   import pssq_pkg::*;
   logic CLK = 0, RST_B = 0, HSEL = 0, HWRITE = 0, HREADY, SLOW = 0;
   logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, rd, d;
   logic [1:0] HTRANS = 0;
   logic [2:0] HSIZE = 3'h2, CLK_DIV_SEL;
   logic HREADYOUT, HRESP, BAT_GOOD = 0, RF_GOOD = 0, RF_FIELD = 0, RESET_PIN_B = 1;
   logic WAKE_PIN = 1, BROWNOUT_LOW = 0, RTC_EVENT = 0, WDT_EVENT = 0, START_IRQ = 0;
   logic FAST_OSC_OK, FLASH_READY, BAT_SWITCH_ON, RF_SWITCH_ON, SRC_IS_RF, CMP_EN;
   logic ALWAYS_ON_PWR, DIG_REG_EN, ANA_REG_EN, SLOW_OSC_EN, SYS_POR_B, BOOT_EN;
   logic DPD_FLAG, SLEEP_FLAG, DEEP_SLEEP, BOD_IRQ, SYS_RST_B, dig_q, ana_q, por_q, boot_q;
   int failures = 0, samples_checked = 0, cyc = 0, dig_t = 0, ana_t = 0, i, k;
   assign HREADY = HREADYOUT;
   pssq_top #(.BOOT_CYC(10)) DUT (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .BAT_GOOD(BAT_GOOD),
      .RF_GOOD(RF_GOOD), .RF_FIELD(RF_FIELD), .RESET_PIN_B(RESET_PIN_B),
      .WAKE_PIN(WAKE_PIN), .BROWNOUT_LOW(BROWNOUT_LOW), .RTC_EVENT(RTC_EVENT),
      .WDT_EVENT(WDT_EVENT), .START_IRQ(START_IRQ), .FAST_OSC_OK(FAST_OSC_OK),
      .FLASH_READY(FLASH_READY), .BAT_SWITCH_ON(BAT_SWITCH_ON), .RF_SWITCH_ON(RF_SWITCH_ON),
      .SRC_IS_RF(SRC_IS_RF), .CMP_EN(CMP_EN), .ALWAYS_ON_PWR(ALWAYS_ON_PWR),
      .DIG_REG_EN(DIG_REG_EN), .ANA_REG_EN(ANA_REG_EN), .SLOW_OSC_EN(SLOW_OSC_EN),
      .SYS_POR_B(SYS_POR_B), .BOOT_EN(BOOT_EN), .DPD_FLAG(DPD_FLAG), .SLEEP_FLAG(SLEEP_FLAG),
      .DEEP_SLEEP(DEEP_SLEEP), .BOD_IRQ(BOD_IRQ), .SYS_RST_B(SYS_RST_B),
      .CLK_DIV_SEL(CLK_DIV_SEL));
   pssq_far FAR (.CLK(CLK), .SLOW(SLOW), .DIG_REG_EN(DIG_REG_EN), .ANA_REG_EN(ANA_REG_EN),
      .FAST_OSC_OK(FAST_OSC_OK), .FLASH_READY(FLASH_READY));
   initial begin
      forever #25 CLK = ~CLK;
   end
   initial begin
      repeat (60000) @(posedge CLK);
      failures++;
      results();
   end
   task automatic results();
      if (failures == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [31:0] bit_of(int b);
      return 32'h1 << b;
   endfunction
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, a};
      HWRITE <= w;
      do @(posedge CLK); while (HREADY !== 1'b1);
      HTRANS <= 2'h0;
      HSEL <= 1'b0;
      HWDATA <= wd;
      do @(posedge CLK); while (HREADY !== 1'b1);
      rd = HRDATA;
   endtask
   task automatic waitc(int n);
      repeat (n) @(posedge CLK);
   endtask
   task automatic boot();
      for (i = 0; i < 400 && BOOT_EN !== 1'b1; i++) @(posedge CLK);
      chk("boot_en", 1, BOOT_EN);
      chk("ana_after_dig", 1, ana_t > dig_t);
      waitc(2);
      bus(0, PSSQ_STAT_OFS, 0);
      chk("state_active", {29'h0, PSSQ_ACTIVE}, {29'h0, rd[2:0]});
   endtask
   // latest-rise bookkeeping for the power-up order
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (DIG_REG_EN && !dig_q) dig_t <= cyc;
      if (ANA_REG_EN && !ana_q) ana_t <= cyc;
      if (SYS_POR_B && !por_q) chk("por_cause", 1, DIG_REG_EN & FAST_OSC_OK);
      if (BOOT_EN && !boot_q) chk("boot_flash", 1, FLASH_READY);
      dig_q <= DIG_REG_EN;
      ana_q <= ANA_REG_EN;
      por_q <= SYS_POR_B;
      boot_q <= BOOT_EN;
   end
   initial begin
      void'($urandom(32'h1a72));
      waitc(3);
      RST_B <= 1'b1;
      bus(0, PSSQ_CLKDIV_OFS, 0);
      chk("clkdiv_rst", {29'h0, PSSQ_CLKDIV_RST}, rd);
      chk("osc_en", 1, SLOW_OSC_EN);
      bus(0, 8'h10, 0);
      chk("unmapped", 0, rd);
      chk("hresp", 0, HRESP);
      BAT_GOOD <= 1'b1;
      waitc(20);
      chk("bat_sw_idle", 0, BAT_SWITCH_ON);
      RESET_PIN_B <= 1'b0;
      waitc(10);
      RESET_PIN_B <= 1'b1;
      boot();
      chk("src_bat", 0, SRC_IS_RF);
      for (k = 0; k < 8; k++) begin
         d = $urandom;
         d[2:0] = k[2:0];
         bus(1, PSSQ_CLKDIV_OFS, d);
         bus(0, PSSQ_CLKDIV_OFS, 0);
         chk("clkdiv", {29'h0, d[2:0]}, {29'h0, CLK_DIV_SEL});
      end
      BAT_GOOD <= 1'b0;
      RF_GOOD <= 1'b1;
      RF_FIELD <= 1'b1;
      waitc(8);
      chk("src_rf", 1, SRC_IS_RF);
      chk("rf_sw", 1, RF_SWITCH_ON & ALWAYS_ON_PWR);
      BAT_GOOD <= 1'b1;
      waitc(8);
      chk("src_back", 0, SRC_IS_RF);
      bus(1, PSSQ_CTRL_OFS, bit_of(PSSQ_CTRL_AUTO_DIS));
      BAT_GOOD <= 1'b0;
      waitc(8);
      chk("forced", 0, {CMP_EN, SRC_IS_RF});
      bus(1, PSSQ_CTRL_OFS, 0);
      BROWNOUT_LOW <= 1'b1;
      waitc(8);
      chk("bod_off", 0, BOD_IRQ);
      bus(1, PSSQ_CTRL_OFS, bit_of(PSSQ_CTRL_BOD_EN));
      waitc(2);
      chk("bod_on", 1, BOD_IRQ);
      BROWNOUT_LOW <= 1'b0;
      // deep-sleep wakes on a high wake pin, so park it low well before sleeping
      WAKE_PIN <= 1'b0;
      bus(1, PSSQ_CTRL_OFS, bit_of(PSSQ_CTRL_DIG_OFF));
      waitc(2);
      chk("dig_off", 2'b01, {DIG_REG_EN, ANA_REG_EN});
      bus(1, PSSQ_CTRL_OFS, bit_of(PSSQ_CTRL_ANA_OFF));
      waitc(2);
      chk("ana_off", 2'b10, {DIG_REG_EN, ANA_REG_EN});
      bus(1, PSSQ_CTRL_OFS, 0);
      for (k = 0; k < 3; k++) begin
         bus(1, PSSQ_CTRL_OFS, bit_of(PSSQ_CTRL_SLEEP_REQ) | bit_of(PSSQ_CTRL_DEEP_REQ));
         waitc(3);
         chk("deep_sleep", 5'b11011, {SLEEP_FLAG, DEEP_SLEEP, DPD_FLAG, DIG_REG_EN,
            ANA_REG_EN});
         {RTC_EVENT, WDT_EVENT, START_IRQ} <= 3'b001 << k;
         waitc(8);
         {RTC_EVENT, WDT_EVENT, START_IRQ} <= 3'b000;
         waitc(4);
         chk("sleep_wake", 0, SLEEP_FLAG);
      end
      RF_FIELD <= 1'b0;
      WAKE_PIN <= 1'b1;
      RF_GOOD <= 1'b0;
      BAT_GOOD <= 1'b1;
      bus(1, PSSQ_WAKE_OFS, bit_of(PSSQ_WAKE_PIN_EN));
      for (k = 0; k < 2; k++) begin
         bus(1, PSSQ_CTRL_OFS, bit_of(PSSQ_CTRL_DPD_REQ));
         waitc(3);
         chk("dpd", 3'b100, {DPD_FLAG, DIG_REG_EN, ANA_REG_EN});
         {WDT_EVENT, START_IRQ} <= 2'b11;
         waitc(20);
         {WDT_EVENT, START_IRQ} <= 2'b00;
         chk("dpd_hold", 1, DPD_FLAG);
         SLOW <= k[0];
         if (k == 0) begin
            RTC_EVENT <= 1'b1;
            waitc(8);
            RTC_EVENT <= 1'b0;
         end else begin
            WAKE_PIN <= 1'b0;
            waitc(PSSQ_WAKE_LOW_CYC + 10);
            WAKE_PIN <= 1'b1;
         end
         boot();
      end
      bus(1, PSSQ_CTRL_OFS, bit_of(PSSQ_CTRL_BAT_OPEN));
      waitc(3);
      chk("bat_open", 0, {BAT_SWITCH_ON, ALWAYS_ON_PWR});
      bus(0, PSSQ_STAT_OFS, 0);
      chk("batoff", {29'h0, PSSQ_BATOFF}, {29'h0, rd[2:0]});
      BAT_GOOD <= 1'b0;
      RF_GOOD <= 1'b1;
      RF_FIELD <= 1'b1;
      boot();
      chk("rf_only", 1, SRC_IS_RF);
      bus(1, PSSQ_CTRL_OFS, bit_of(PSSQ_CTRL_SW_RST));
      for (i = 0; i < 10 && SYS_RST_B !== 1'b0; i++) @(posedge CLK);
      chk("sw_rst", 0, SYS_RST_B);
      results();
   end
endmodule
